// *** hw/loopback_diag_indication.sv ***
// Loopback control, diagnostic priority and transmit indication for one channel
// What this block does
// - Select 000: pin high in pattern sync, low one line cycle per error.
// - Select 001: pin follows system-side AIS status.
// - Select 010: pin follows transmit over-current status.
// - Select 011: pin follows transmit line-side LOS status.
// - Select 100: pin pulses one line cycle per excessive-zeroes event.
// - Select 101 pulses on violations; 110 on zeroes or violations.
// - Select 111: pin follows system-side LOS status.
// - Single-rail NRZ mode disables selections 101, 110 and 111.
// - Analog loop sends transmit data to line and replaces received data.
// - Analog loop disables remote and digital loops, manual or automatic.
// - Analog loop: receive pattern beats looped data; AIS off both ways.
// - Remote loop from manual bit, or auto with detector in receive path.
// - Auto remote loop enters/leaves after codes persist over 5.1 s.
// - Clearing auto enable ends auto loop; status bit shows auto active.
// - Remote loop: received data to shaper and system; system data ignored.
// - Remote loop: transmit detectors keep watching system-side data.
// - Remote loop priorities; receive pattern over AIS, transmit AIS off.
// - Digital loop from manual bit, or auto with detector in transmit path.
// - Digital loop: transmit data to decoder and line; line detectors stay.
// - Digital loop priorities; receive AIS generation disabled.
// - Dual loop only with manual remote; no auto remote during digital.
// - Dual loop: both paths looped; receive detectors watch looped data.
// - Manual dual loop: remote data beats transmit pattern; AIS off.
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "loop_diag_cfg.svh"

module loopback_diag_indication #(
  parameter logic [`HOLD_CNT_W-1:0] HOLD_CYCLES =
    `HOLD_CNT_W'(`INBAND_HOLD_MS * `CLK_FREQ_KHZ)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Line clock from outside
  input  wire logic        line_clk_i,
  // Transmit-path detector status
  input  wire logic        pattern_sync_i,
  input  wire logic        pattern_err_i,
  input  wire logic        sys_alarm_status_i,
  input  wire logic        tx_overcurrent_status_i,
  input  wire logic        tx_line_los_status_i,
  input  wire logic        sys_los_status_i,
  input  wire logic        sys_excess_zeros_i,
  input  wire logic        sys_violation_i,
  // Inband loop code detectors
  input  wire logic        rx_act_code_i,
  input  wire logic        rx_deact_code_i,
  input  wire logic        tx_act_code_i,
  input  wire logic        tx_deact_code_i,
  // Data streams and generators
  input  wire logic        line_rx_data_i,
  input  wire logic        sys_tx_data_i,
  input  wire logic        rx_pattern_data_i,
  input  wire logic        tx_pattern_data_i,
  input  wire logic        rx_pattern_gen_i,
  input  wire logic        tx_pattern_gen_i,
  input  wire logic        rx_ais_gen_i,
  input  wire logic        tx_ais_gen_i,
  output logic             line_tx_data_o,
  output logic             sys_rx_data_o,
  output logic             rx_decoder_data_o,
  output logic             sys_tx_monitor_o,
  // Loop state and transmit indication pin
  output logic             analog_loop_o,
  output logic             remote_loop_o,
  output logic             digital_loop_o,
  output logic             auto_loop_active_o,
  output logic             tx_indication_pin_o
);

  // ****************************************************************
  // Line clock edge detection
  // ****************************************************************
  logic       lclk_meta_q;
  logic       lclk_sync_q;
  logic       lclk_prev_q;
  logic       line_tick;

  always_comb
  begin
    line_tick = lclk_sync_q & ~lclk_prev_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      lclk_meta_q <= 1'b0;
      lclk_sync_q <= 1'b0;
      lclk_prev_q <= 1'b0;
    end
    else
    begin
      lclk_meta_q <= line_clk_i;
      lclk_sync_q <= lclk_meta_q;
      lclk_prev_q <= lclk_sync_q;
    end
  end

  // ****************************************************************
  // AHB-Lite register slave
  // ****************************************************************
  logic [`CTRL_WIDTH-1:0] ctrl_q;
  logic [`CTRL_WIDTH-1:0] ctrl_d;
  logic                   wr_pend_q;
  logic                   wr_pend_d;
  logic [7:0]             waddr_q;
  logic [7:0]             waddr_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic [`STAT_WIDTH-1:0] status;
  logic                   addr_phase;

  always_comb
  begin
    addr_phase = hsel_i & htrans_i[1] & hready_i;
    wr_pend_d  = addr_phase & hwrite_i;
    waddr_d    = addr_phase ? haddr_i[7:0] : waddr_q;
    ctrl_d     = ctrl_q;
    if (wr_pend_q && waddr_q == `LOOP_CTRL_OFFSET)
    begin
      ctrl_d = hwdata_i[`CTRL_WIDTH-1:0];
    end
    rdata_d = rdata_q;
    if (addr_phase && !hwrite_i)
    begin
      case (haddr_i[7:0])
        `LOOP_CTRL_OFFSET:   rdata_d = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
        `LOOP_STATUS_OFFSET: rdata_d = {{(32-`STAT_WIDTH){1'b0}}, status};
        default:             rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q    <= `CTRL_RESET;
      wr_pend_q <= 1'b0;
      waddr_q   <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      wr_pend_q <= wr_pend_d;
      waddr_q   <= waddr_d;
      rdata_q   <= rdata_d;
    end
  end

  assign hrdata_o    = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ****************************************************************
  // Automatic loopback from inband codes
  // ****************************************************************
  logic                    analog_en;
  logic                    remote_man;
  logic                    digital_man;
  logic                    auto_en;
  logic                    place_tx;
  loop_diag_pkg::auto_state_t auto_q;
  loop_diag_pkg::auto_state_t auto_d;
  logic [`HOLD_CNT_W-1:0]  hold_q;
  logic [`HOLD_CNT_W-1:0]  hold_d;
  logic                    auto_allowed;
  logic                    code_seen;

  always_comb
  begin
    analog_en   = ctrl_q[`CTRL_ANALOG_BIT];
    remote_man  = ctrl_q[`CTRL_REMOTE_BIT];
    digital_man = ctrl_q[`CTRL_DIGITAL_BIT];
    auto_en     = ctrl_q[`CTRL_AUTO_BIT];
    // Placement is assumed stable while the auto loop is on
    place_tx    = ctrl_q[`CTRL_PLACE_BIT];
    // No auto remote while digital loop is on
    auto_allowed = auto_en & ~analog_en & (place_tx | ~digital_man);
    // Qualifying code depends on state and detector path
    if (auto_q == loop_diag_pkg::AUTO_ON)
    begin
      code_seen = place_tx ? tx_deact_code_i : rx_deact_code_i;
    end
    else
    begin
      code_seen = place_tx ? tx_act_code_i : rx_act_code_i;
    end
    auto_d = auto_q;
    hold_d = hold_q;
    if (!auto_allowed)
    begin
      auto_d = loop_diag_pkg::AUTO_OFF;
      hold_d = '0;
    end
    else if (!code_seen)
    begin
      hold_d = '0;
    end
    else if (hold_q == HOLD_CYCLES)
    begin
      hold_d = '0;
      case (auto_q)
        loop_diag_pkg::AUTO_OFF: auto_d = loop_diag_pkg::AUTO_ON;
        loop_diag_pkg::AUTO_ON:  auto_d = loop_diag_pkg::AUTO_OFF;
        default:                 auto_d = loop_diag_pkg::AUTO_OFF;
      endcase
    end
    else
    begin
      hold_d = hold_q + `HOLD_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      auto_q <= loop_diag_pkg::AUTO_OFF;
      hold_q <= '0;
    end
    else
    begin
      auto_q <= auto_d;
      hold_q <= hold_d;
    end
  end

  // ****************************************************************
  // Loop selection and diagnostic priority
  // ****************************************************************
  logic auto_on;
  logic remote;
  logic digital;
  logic dual;
  logic rx_src_d;
  logic sys_rx_d;
  logic line_tx_d;
  logic line_tx_q;
  logic sys_rx_q;
  logic rx_dec_q;
  logic tx_mon_q;

  always_comb
  begin
    auto_on = (auto_q == loop_diag_pkg::AUTO_ON) & auto_allowed;
    remote  = ~analog_en & (remote_man | (auto_on & ~place_tx));
    digital = ~analog_en & (digital_man | (auto_on & place_tx));
    dual    = remote & digital;
    // Receive decoder source: looped transmit data or line
    if (analog_en)
    begin
      rx_src_d = line_tx_q;
    end
    else if (digital)
    begin
      rx_src_d = sys_tx_data_i;
    end
    else
    begin
      rx_src_d = line_rx_data_i;
    end
    // Receive path toward the system
    if (rx_pattern_gen_i)
    begin
      sys_rx_d = rx_pattern_data_i;
    end
    else if (rx_ais_gen_i && !analog_en && !digital)
    begin
      sys_rx_d = 1'b1;
    end
    else
    begin
      sys_rx_d = rx_src_d;
    end
    // Transmit path toward the line
    if (dual)
    begin
      line_tx_d = line_rx_data_i;
    end
    else if (tx_pattern_gen_i)
    begin
      line_tx_d = tx_pattern_data_i;
    end
    else if (remote)
    begin
      line_tx_d = line_rx_data_i;
    end
    else if (digital || analog_en)
    begin
      line_tx_d = sys_tx_data_i;
    end
    else if (tx_ais_gen_i)
    begin
      line_tx_d = 1'b1;
    end
    else
    begin
      line_tx_d = sys_tx_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      line_tx_q <= 1'b0;
      sys_rx_q  <= 1'b0;
      rx_dec_q  <= 1'b0;
      tx_mon_q  <= 1'b0;
    end
    else if (line_tick)
    begin
      line_tx_q <= line_tx_d;
      sys_rx_q  <= sys_rx_d;
      rx_dec_q  <= rx_src_d;
      tx_mon_q  <= sys_tx_data_i;
    end
  end

  assign line_tx_data_o     = line_tx_q;
  assign sys_rx_data_o      = sys_rx_q;
  assign rx_decoder_data_o  = rx_dec_q;
  assign sys_tx_monitor_o   = tx_mon_q;

  // ****************************************************************
  // Transmit indication pin
  // ****************************************************************
  logic [2:0] ev_q;
  logic [2:0] ev_d;
  logic [2:0] ev_now;
  logic       pin_q;
  logic       pin_d;
  logic       nrz_mode;
  loop_diag_pkg::ind_sel_t sel;

  always_comb
  begin
    sel      = loop_diag_pkg::ind_sel_t'(ctrl_q[`CTRL_SEL_MSB:`CTRL_SEL_LSB]);
    nrz_mode = ctrl_q[`CTRL_NRZ_BIT];
    // Events held until the next line cycle; one arriving on that cycle counts there, then is cleared
    ev_now = ev_q | {sys_violation_i, sys_excess_zeros_i, pattern_err_i};
    ev_d   = line_tick ? 3'h0 : ev_now;
    pin_d  = pin_q;
    if (line_tick)
    begin
      case (sel)
        loop_diag_pkg::IND_PATTERN:      pin_d = pattern_sync_i & ~ev_now[0];
        loop_diag_pkg::IND_SYS_AIS:      pin_d = sys_alarm_status_i;
        loop_diag_pkg::IND_OVERCURRENT:  pin_d = tx_overcurrent_status_i;
        loop_diag_pkg::IND_TX_LINE_LOS:  pin_d = tx_line_los_status_i;
        loop_diag_pkg::IND_EXCESS_ZEROS: pin_d = ev_now[1];
        loop_diag_pkg::IND_VIOLATION:    pin_d = ~nrz_mode & ev_now[2];
        loop_diag_pkg::IND_ZEROS_OR_VIOL: pin_d = ~nrz_mode & (ev_now[1] | ev_now[2]);
        loop_diag_pkg::IND_SYS_LOS:      pin_d = ~nrz_mode & sys_los_status_i;
        default:                         pin_d = 1'b0;
      endcase
    end
    status = {sys_los_status_i, tx_line_los_status_i, tx_overcurrent_status_i,
              sys_alarm_status_i, pin_q, digital, remote, analog_en, auto_on};
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ev_q  <= 3'h0;
      pin_q <= 1'b0;
    end
    else
    begin
      ev_q  <= ev_d;
      pin_q <= pin_d;
    end
  end

  assign tx_indication_pin_o = pin_q;
  assign analog_loop_o       = analog_en;
  assign remote_loop_o       = remote;
  assign digital_loop_o      = digital;
  assign auto_loop_active_o  = auto_on;

endmodule

// *** hw/loop_diag_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the loopback block
`ifndef LOOP_DIAG_CFG_SVH
`define LOOP_DIAG_CFG_SVH

// Register byte offsets
`define LOOP_CTRL_OFFSET   8'h00
`define LOOP_STATUS_OFFSET 8'h04

// Control register fields
`define CTRL_ANALOG_BIT    0
`define CTRL_REMOTE_BIT    1
`define CTRL_DIGITAL_BIT   2
`define CTRL_AUTO_BIT      3
`define CTRL_PLACE_BIT     4
`define CTRL_SEL_LSB       5
`define CTRL_SEL_MSB       7
`define CTRL_NRZ_BIT       8
`define CTRL_WIDTH         9
`define CTRL_RESET         9'h000

// Status register fields
`define STAT_AUTO_BIT      0
`define STAT_ANALOG_BIT    1
`define STAT_REMOTE_BIT    2
`define STAT_DIGITAL_BIT   3
`define STAT_PIN_BIT       4
`define STAT_SYS_ALARM_INDICATION_BIT      5
`define STAT_TOC_BIT       6
`define STAT_TX_LINE_LOS_BIT      7
`define STAT_SYS_LOS_BIT      8
`define STAT_WIDTH         9

// Inband code persistence time
`define INBAND_HOLD_MS     5100
`define CLK_FREQ_KHZ       25000
`define HOLD_CNT_W         27

`endif

// *** hw/loop_diag_pkg.sv ***
// Types shared by the loopback and indication logic
package loop_diag_pkg;

  typedef enum logic [2:0] {
    IND_PATTERN,
    IND_SYS_AIS,
    IND_OVERCURRENT,
    IND_TX_LINE_LOS,
    IND_EXCESS_ZEROS,
    IND_VIOLATION,
    IND_ZEROS_OR_VIOL,
    IND_SYS_LOS
  } ind_sel_t;

  typedef enum {
    AUTO_OFF,
    AUTO_ON
  } auto_state_t;

endpackage

// *** testbench/loop_diag_props.sv ***
// Port checker of the loopback and indication block
`timescale 1ns/100ps
module loop_diag_props #(
  parameter logic [26:0] HOLD_CYCLES = 27'h0000014
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        rx_act_code_i,
  input wire logic        tx_act_code_i,
  input wire logic        line_tx_data_o,
  input wire logic        analog_loop_o,
  input wire logic        remote_loop_o,
  input wire logic        digital_loop_o,
  input wire logic        auto_loop_active_o,
  input wire logic        tx_indication_pin_o
);
  // ***************
  // Code run length
  // ***************
  logic [26:0] run_q;
  logic [26:0] run_d;
  always_comb run_d = (rx_act_code_i || tx_act_code_i) ? run_q + 27'h0000001 : 27'h0000000;
  always_ff @(posedge clk_i) run_q <= rst_n_i ? run_d : 27'h0000000;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  a_reset_quiet: assert property ($rose(rst_n_i) |-> !analog_loop_o && !remote_loop_o
    && !digital_loop_o && !tx_indication_pin_o && hrdata_o == 32'h00000000)
    else $error("outputs not quiet after reset");
  a_analog_excl: assert property (analog_loop_o |-> !remote_loop_o && !digital_loop_o)
    else $error("loop beside analog loop");
  a_auto_loops: assert property (auto_loop_active_o |-> remote_loop_o || digital_loop_o)
    else $error("auto active without a loop");
  a_auto_wait: assert property ($rose(auto_loop_active_o) |-> run_q >= HOLD_CYCLES)
    else $error("auto loop entered early");
  a_pin_holds: assert property ($changed(tx_indication_pin_o) |=> $stable(tx_indication_pin_o) [*6])
    else $error("indication shorter than a line cycle");
  a_data_holds: assert property ($changed(line_tx_data_o) |=> $stable(line_tx_data_o) [*6])
    else $error("line data shorter than a line cycle");
  a_rdata_holds: assert property (!$past(hsel_i && htrans_i[1] && hready_i && !hwrite_i)
    |-> $stable(hrdata_o))
    else $error("read data changed without a read");
endmodule
bind loopback_diag_indication loop_diag_props #(.HOLD_CYCLES(HOLD_CYCLES)) props (
  .clk_i, .rst_n_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o,
  .hresp_o, .rx_act_code_i, .tx_act_code_i, .line_tx_data_o, .analog_loop_o,
  .remote_loop_o, .digital_loop_o, .auto_loop_active_o, .tx_indication_pin_o);

// *** testbench/line_partner.sv ***
// Line and framer model: free-running line clock and launched data bits
`timescale 1ns/100ps
module line_partner (
  input  wire logic rx_val_i,
  input  wire logic tx_val_i,
  output logic      line_clk_o = 1'b0,
  output logic      line_rx_o = 1'b0,
  output logic      sys_tx_o = 1'b0
);
  initial
  begin
    #7;
    forever #160 line_clk_o = ~line_clk_o;
  end
  // Bits change on the falling edge, so they are settled at the rising one
  always @(negedge line_clk_o)
  begin
    line_rx_o <= rx_val_i;
    sys_tx_o <= tx_val_i;
  end
endmodule

// *** testbench/loopback_diag_indication_test.sv ***
// Self-checking bench of the loopback and indication block
`timescale 1ns/100ps
module loopback_diag_indication_test;
  // *******
  // Signals
  // *******
  logic        clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
  logic [4:0]  lvl = 5'h00;
  logic        pattern_err_i = 1'b0, sys_excess_zeros_i = 1'b0, sys_violation_i = 1'b0;
  logic        rx_act_code_i = 1'b0, rx_deact_code_i = 1'b0, tx_act_code_i = 1'b0;
  logic        rx_pattern_gen_i = 1'b0, tx_pattern_gen_i = 1'b0, rx_ais_gen_i = 1'b0;
  logic        tx_ais_gen_i = 1'b0, rx_val = 1'b0, tx_val = 1'b0, tx_deact_code_i = 1'b0;
  logic        hreadyout_o, hresp_o, line_clk_i, line_rx_data_i, sys_tx_data_i;
  logic        line_tx_data_o, sys_rx_data_o, rx_decoder_data_o, sys_tx_monitor_o;
  logic        analog_loop_o, remote_loop_o, digital_loop_o, auto_loop_active_o;
  logic        tx_indication_pin_o;
  int          num_errors = 0, comparisons = 0, cycles = 0;
  loopback_diag_indication #(.HOLD_CYCLES(27'h0000014)) uut (
    .clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
    .hready_i(hreadyout_o), .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .line_clk_i,
    .pattern_sync_i(lvl[4]), .pattern_err_i, .sys_alarm_status_i(lvl[0]),
    .tx_overcurrent_status_i(lvl[1]), .tx_line_los_status_i(lvl[2]),
    .sys_los_status_i(lvl[3]), .sys_excess_zeros_i, .sys_violation_i, .rx_act_code_i,
    .rx_deact_code_i, .tx_act_code_i, .tx_deact_code_i, .line_rx_data_i,
    .sys_tx_data_i, .rx_pattern_data_i(1'b1), .tx_pattern_data_i(1'b0), .rx_pattern_gen_i,
    .tx_pattern_gen_i, .rx_ais_gen_i, .tx_ais_gen_i, .line_tx_data_o, .sys_rx_data_o,
    .rx_decoder_data_o, .sys_tx_monitor_o, .analog_loop_o, .remote_loop_o,
    .digital_loop_o, .auto_loop_active_o, .tx_indication_pin_o);
  line_partner far_end (.rx_val_i(rx_val), .tx_val_i(tx_val), .line_clk_o(line_clk_i),
    .line_rx_o(line_rx_data_i), .sys_tx_o(sys_tx_data_i));
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      num_errors++;
      tally_and_finish;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task t_regs;
    rd_chk(8'h00, 32'h0);
    wr(8'h00, 32'hFFFFFEE0);
    rd_chk(8'h00, 32'h000000E0);
    wr(8'h04, 32'hFFFFFFFF);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h40, 32'h0);
  endtask
  task t_levels;
    logic [2:0] s;
    for (int i = 0; i < 5; i++)
    begin
      s = (i == 4) ? 3'h0 : (i == 3) ? 3'h7 : 3'(i + 1);
      wr(8'h00, {24'h0, s, 5'h00});
      lvl <= 5'h01 << i;
      repeat (24) @(posedge clk_i);
      chk({31'h0, tx_indication_pin_o}, 32'h1);
      if (i < 4) rd_chk(8'h04, 32'h10 | (32'h20 << i));
      lvl <= 5'h00;
      repeat (24) @(posedge clk_i);
      chk({31'h0, tx_indication_pin_o}, 32'h0);
    end
    wr(8'h00, 32'h1E0);
    lvl <= 5'h08;
    repeat (24) @(posedge clk_i);
    chk({31'h0, tx_indication_pin_o}, 32'h0);
  endtask
  task pulse(input logic [8:0] c, input logic [2:0] ev, input logic [31:0] n);
    logic [31:0] k;
    wr(8'h00, {23'h0, c});
    lvl <= {c[7:5] == 3'h0, 4'h0};
    repeat (24) @(posedge clk_i);
    {pattern_err_i, sys_excess_zeros_i, sys_violation_i} <= ev;
    @(posedge clk_i);
    {pattern_err_i, sys_excess_zeros_i, sys_violation_i} <= 3'h0;
    k = 32'h0;
    repeat (32)
    begin
      @(posedge clk_i);
      k = k + {31'h0, tx_indication_pin_o !== lvl[4]};
    end
    chk(k, n);
  endtask
  task path(input logic [8:0] c, input logic [5:0] v, input logic [3:0] m, e,
            input logic [2:0] l);
    wr(8'h00, {23'h0, c});
    {rx_pattern_gen_i, tx_pattern_gen_i, rx_ais_gen_i, tx_ais_gen_i, rx_val, tx_val} <= v;
    repeat (32) @(posedge clk_i);
    chk({28'h0, m & {line_tx_data_o, sys_rx_data_o, rx_decoder_data_o, sys_tx_monitor_o}},
        {28'h0, e});
    chk({29'h0, analog_loop_o, remote_loop_o, digital_loop_o}, {29'h0, l});
  endtask
  task t_auto;
    wr(8'h00, 32'h008);
    rx_act_code_i <= 1'b1;
    repeat (15) @(posedge clk_i);
    rx_act_code_i <= 1'b0;
    @(posedge clk_i);
    rx_act_code_i <= 1'b1;
    repeat (15) @(posedge clk_i);
    chk({30'h0, auto_loop_active_o, remote_loop_o}, 32'h0);
    repeat (10) @(posedge clk_i);
    chk({30'h0, auto_loop_active_o, remote_loop_o}, 32'h3);
    rd_chk(8'h04, 32'h5);
    rx_act_code_i <= 1'b0;
    rx_deact_code_i <= 1'b1;
    repeat (25) @(posedge clk_i);
    chk({30'h0, auto_loop_active_o, remote_loop_o}, 32'h0);
    rx_deact_code_i <= 1'b0;
    rx_act_code_i <= 1'b1;
    repeat (25) @(posedge clk_i);
    wr(8'h00, 32'h0);
    @(posedge clk_i);
    chk({30'h0, auto_loop_active_o, remote_loop_o}, 32'h0);
    wr(8'h00, 32'h00C);
    repeat (25) @(posedge clk_i);
    chk({29'h0, auto_loop_active_o, remote_loop_o, digital_loop_o}, 32'h1);
    rx_act_code_i <= 1'b0;
    wr(8'h00, 32'h01A);
    tx_act_code_i <= 1'b1;
    repeat (25) @(posedge clk_i);
    chk({29'h0, auto_loop_active_o, remote_loop_o, digital_loop_o}, 32'h7);
    tx_act_code_i <= 1'b0;
    tx_deact_code_i <= 1'b1;
    repeat (25) @(posedge clk_i);
    chk({29'h0, auto_loop_active_o, remote_loop_o, digital_loop_o}, 32'h2);
    tx_deact_code_i <= 1'b0;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs;
    t_levels;
    pulse(9'h080, 3'h2, 32'h8);
    pulse(9'h080, 3'h1, 32'h0);
    pulse(9'h0A0, 3'h1, 32'h8);
    pulse(9'h0C0, 3'h3, 32'h8);
    pulse(9'h0C0, 3'h2, 32'h8);
    pulse(9'h000, 3'h4, 32'h8);
    pulse(9'h1A0, 3'h1, 32'h0);
    pulse(9'h1C0, 3'h3, 32'h0);
    path(9'h000, 6'h02, 4'hF, 4'h6, 3'h0);
    path(9'h001, 6'h06, 4'hF, 4'h0, 3'h4);
    path(9'h001, 6'h20, 4'h4, 4'h4, 3'h4);
    path(9'h007, 6'h00, 4'h0, 4'h0, 3'h4);
    path(9'h002, 6'h05, 4'hF, 4'h1, 3'h2);
    path(9'h002, 6'h12, 4'h8, 4'h0, 3'h2);
    path(9'h004, 6'h0E, 4'hF, 4'h0, 3'h1);
    path(9'h006, 6'h12, 4'hB, 4'h8, 3'h3);
    t_auto;
    tally_and_finish;
  end
endmodule
